// File: src/mov_fault_response.sv
// Monitor overvoltage fault response controller
// Overview of operation
// - Mode 00 ignores the overvoltage fault, mode 10 turns the output off at once and then follows the retry setting.
// - Mode 11 holds the output off only while the overvoltage persists and re-enables it once it is gone.
// - In modes 10 and 11 a fault pulls the alert line low and sets the overvoltage fault flag.
// - Fault flags stay set until the clear-faults command or a reset, and nothing else clears them.
// - Retry setting 000 makes no restart and keeps the output off until faults are cleared.
// - Retry setting 111 restarts repeatedly, each time only once the voltage is below the restart level.
// - Continuous retrying stops on a commanded off, loss of bias power or a shutdown by another fault.
// - A retry restart begins only after the monitored voltage falls below 95% of the fault limit.
// - Restart attempts start (retry delay + 1) times 35 ms apart, 35 ms to 280 ms.
// - The overvoltage warning threshold is 90% of the fault limit.
module mov_fault_response
  import mov_pkg::*;
#(
  parameter int STEP_CYCLES = RETRY_STEP_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_code,
  input  wire logic [7:0]  wr_data,
  input  wire logic        rd_en,
  input  wire logic [7:0]  rd_code,
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  input  wire logic        clear_faults,
  input  wire logic [15:0] aux_voltage_monitor_input,
  input  wire logic [15:0] monitor_overvoltage_limit,
  input  wire logic        control_pin_on,
  input  wire logic        operation_on,
  input  wire logic        bias_ok,
  input  wire logic        other_fault_shutdown,
  output logic             output_enable,
  output logic             alert_output_n,
  output logic             ov_fault_flag,
  output logic             ov_warn_flag
);

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic [23:0] scale_pct(input logic [15:0] v, input logic [7:0] pct);
    scale_pct = 24'(v) * 24'(pct);
  endfunction : scale_pct

  logic [7:0]  monitor_overvoltage_response;
  logic        ctl_meta;
  logic        ctl_sync;
  logic        run_allowed;
  logic        ov_fault;
  logic        below_restart;
  logic        ov_warn;
  logic        fault_active;
  logic [1:0]  mode;
  logic [2:0]  retry;
  logic        timer_start;
  logic        timer_done;
  mov_state_t  state;
  mov_state_t  next_state;

  assign mode  = monitor_overvoltage_response[MODE_HI:MODE_LO];
  assign retry = monitor_overvoltage_response[RETRY_HI:RETRY_LO];

  // ----------------------------------------
  // Control pin synchroniser
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctl_meta <= 1'b0;
      ctl_sync <= 1'b0;
    end else begin
      ctl_meta <= control_pin_on;
      ctl_sync <= ctl_meta;
    end
  end

  assign run_allowed = ctl_sync && operation_on && bias_ok && !other_fault_shutdown;

  // ----------------------------------------
  // Threshold comparison
  // ----------------------------------------
  assign ov_fault      = scale_pct(aux_voltage_monitor_input, PCT_FULL) >
                         scale_pct(monitor_overvoltage_limit, PCT_FULL);
  assign below_restart = scale_pct(aux_voltage_monitor_input, PCT_FULL) <
                         scale_pct(monitor_overvoltage_limit, PCT_RESTART);
  assign ov_warn       = scale_pct(aux_voltage_monitor_input, PCT_FULL) >
                         scale_pct(monitor_overvoltage_limit, PCT_WARN);
  assign fault_active  = ov_fault && (mode != MODE_IGNORE) && (mode != MODE_UNUSED);

  // ----------------------------------------
  // Response register
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      monitor_overvoltage_response <= RESP_RESET;
    end else if (wr_en && wr_code == RESP_OFFSET) begin
      monitor_overvoltage_response <= wr_data;
    end
  end

  // Unmapped codes read as zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= (rd_code == RESP_OFFSET) ? monitor_overvoltage_response : 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Sticky status flags
  // ----------------------------------------
  // fault sets flag
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ov_fault_flag <= 1'b0;
      ov_warn_flag  <= 1'b0;
    end else begin
      ov_fault_flag <= fault_active || (ov_fault_flag && !clear_faults);
      ov_warn_flag  <= (ov_warn && mode[1]) || (ov_warn_flag && !clear_faults);
    end
  end

  assign alert_output_n = !ov_fault_flag;

  // ----------------------------------------
  // Response state machine
  // ----------------------------------------
  always_comb begin
    next_state  = state;
    timer_start = 1'b0;
    case (state)
      ST_RUN: begin
        if (fault_active) begin
          if (mode == MODE_HICCUP) begin
            next_state = ST_HICCUP;
          end else if (retry == RETRY_CONT && run_allowed) begin
            next_state  = ST_RETRY_WAIT;
            timer_start = 1'b1;
          end else begin
            next_state = ST_LATCHED;
          end
        end
      end
      ST_HICCUP: begin
        if (!ov_fault || mode != MODE_HICCUP) begin
          next_state = ST_RUN;
        end
      end
      ST_RETRY_WAIT: begin
        if (!run_allowed || retry != RETRY_CONT) begin
          next_state = ST_LATCHED;
        end else if (timer_done && below_restart) begin
          next_state = ST_RUN;
        end
      end
      ST_LATCHED: begin
        if (clear_faults) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // output off in the same cycle the fault is seen
  assign output_enable = (state == ST_RUN) && !fault_active && run_allowed;

  mov_retry_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_timer (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .start      (timer_start),
    .delay_code (monitor_overvoltage_response[DELAY_HI:DELAY_LO]),
    .done       (timer_done)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // interval reference count
  logic [25:0] gap_cnt;
  logic [2:0]  gap_code;

  // Counts on even when retrying stops, since the timer itself keeps running
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gap_cnt  <= 26'h0;
      gap_code <= 3'h0;
    end else if (timer_start) begin
      gap_cnt  <= 26'h0;
      gap_code <= monitor_overvoltage_response[DELAY_HI:DELAY_LO];
    end else if (gap_cnt != 26'h3ffffff) begin
      gap_cnt  <= gap_cnt + 26'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_ignore_no_flag: assert property (
    (mode == MODE_IGNORE && !ov_fault_flag && !clear_faults) |=> !ov_fault_flag)
    else $error("fault flag set in ignore mode");
  a_fault_alerts: assert property (
    fault_active |=> (ov_fault_flag && !alert_output_n))
    else $error("fault did not raise alert");
  a_flag_sticky: assert property (
    (ov_fault_flag && !clear_faults) |=> ov_fault_flag)
    else $error("fault flag cleared without command");
  a_fault_output_off: assert property (
    fault_active |-> !output_enable)
    else $error("output on during fault");
  a_hiccup_resume: assert property (
    (state == ST_HICCUP && !ov_fault) |=> state == ST_RUN)
    else $error("hiccup did not resume");
  a_noretry_latch: assert property (
    (state == ST_RUN && fault_active && mode == MODE_LATCH && retry != RETRY_CONT)
      |=> state == ST_LATCHED [*2] or (state == ST_LATCHED ##1 $past(clear_faults)))
    else $error("no-retry fault did not latch");
  a_latch_holds: assert property (
    (state == ST_LATCHED && !clear_faults) |=> state == ST_LATCHED)
    else $error("latched state left without clear");
  a_retry_stops: assert property (
    (state == ST_RETRY_WAIT && !run_allowed) |=> state == ST_LATCHED)
    else $error("retry did not stop");
  a_restart_gated: assert property (
    (state == ST_RETRY_WAIT && next_state == ST_RUN) |-> (below_restart && timer_done))
    else $error("restart without interval or low voltage");
  a_retry_spacing: assert property (
    $rose(timer_done) |-> gap_cnt == 26'((int'(gap_code) + 1) * STEP_CYCLES - 1))
    else $error("retry interval length wrong");

  c_latch_fault:  cover property (state == ST_RUN ##1 state == ST_LATCHED);
  c_hiccup_cycle: cover property (state == ST_HICCUP ##[1:20] state == ST_RUN);
  c_retry_restart: cover property (state == ST_RETRY_WAIT ##1 state == ST_RUN);

endmodule : mov_fault_response

// File: src/mov_pkg.sv
// Constants for the monitor overvoltage fault response block
package mov_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] RESP_OFFSET = 8'hf8;
  localparam logic [7:0] RESP_RESET  = 8'hbf;
  localparam int         MODE_HI     = 7;
  localparam int         MODE_LO     = 6;
  localparam int         RETRY_HI    = 5;
  localparam int         RETRY_LO    = 3;
  localparam int         DELAY_HI    = 2;
  localparam int         DELAY_LO    = 0;

  // ----------------------------------------
  // Field encodings
  // ----------------------------------------
  localparam logic [1:0] MODE_IGNORE  = 2'h0;
  localparam logic [1:0] MODE_UNUSED  = 2'h1;
  localparam logic [1:0] MODE_LATCH   = 2'h2;
  localparam logic [1:0] MODE_HICCUP  = 2'h3;
  localparam logic [2:0] RETRY_NONE   = 3'h0;
  localparam logic [2:0] RETRY_CONT   = 3'h7;

  // ----------------------------------------
  // Thresholds in percent of the fault limit
  // ----------------------------------------
  localparam logic [7:0] PCT_FULL    = 8'h64;
  localparam logic [7:0] PCT_RESTART = 8'h5f;
  localparam logic [7:0] PCT_WARN    = 8'h5a;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ        = 200;
  localparam int RETRY_STEP_MS  = 35;
  localparam int RETRY_STEP_CYC = RETRY_STEP_MS * CLK_MHZ * 1000;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_LATCHED,
    ST_HICCUP,
    ST_RETRY_WAIT
  } mov_state_t;

endpackage : mov_pkg

// File: src/mov_retry_timer.sv
// Retry interval timer counting (delay code + 1) steps of one retry unit
module mov_retry_timer
  import mov_pkg::*;
#(
  parameter int STEP_CYCLES = RETRY_STEP_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire logic [2:0] delay_code,
  output logic            done
);

  logic [25:0] cyc_cnt;
  logic [2:0]  step_cnt;
  logic [2:0]  step_last;
  logic        running;

  // Delay code is caught at start so a register write mid-interval has no effect
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cyc_cnt   <= 26'h0;
      step_cnt  <= 3'h0;
      step_last <= 3'h0;
      running   <= 1'b0;
      done      <= 1'b0;
    end else if (start) begin
      // Start edge counts as the first cycle, so the restart lands (code + 1) steps after
      // the shutdown edge; this needs STEP_CYCLES of two or more
      cyc_cnt   <= 26'h1;
      step_cnt  <= 3'h0;
      step_last <= delay_code;
      running   <= 1'b1;
      done      <= 1'b0;
    end else if (running) begin
      if (cyc_cnt == 26'(STEP_CYCLES - 1)) begin
        cyc_cnt <= 26'h0;
        if (step_cnt == step_last) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else begin
          step_cnt <= step_cnt + 3'h1;
        end
      end else begin
        cyc_cnt <= cyc_cnt + 26'h1;
      end
    end
  end

endmodule : mov_retry_timer

// File: tb/mov_host.sv
// Host controller model driving the register strobes and the clear-faults command
module mov_host (
  input  wire logic       core_clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output logic            wr_en,
  output logic      [7:0] wr_code,
  output logic      [7:0] wr_data,
  output logic            rd_en,
  output logic      [7:0] rd_code,
  output logic            clear_faults
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    wr_en = 1'b0;
    wr_code = 8'h00;
    wr_data = 8'h00;
    rd_en = 1'b0;
    rd_code = 8'h00;
    clear_faults = 1'b0;
  end

  // Released data lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(negedge core_clk);
    wr_en = 1'b1;
    wr_code = code;
    wr_data = data;
    @(negedge core_clk);
    wr_en = 1'b0;
    wr_code = ~code;
    wr_data = ~data;
  endtask : wr

  task automatic rd(input logic [7:0] code, output logic [7:0] data);
    @(negedge core_clk);
    rd_en = 1'b1;
    rd_code = code;
    @(negedge core_clk);
    rd_en = 1'b0;
    rd_code = ~code;
    data = rd_valid ? rd_data : 8'hxx;
  endtask : rd

  task automatic clr();
    @(negedge core_clk);
    clear_faults = 1'b1;
    @(negedge core_clk);
    clear_faults = 1'b0;
  endtask : clr
endmodule : mov_host

// File: tb/mov_fault_response_tb.sv
// Self-checking bench for the monitor overvoltage fault response block
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end
module mov_fault_response_tb
  import mov_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          STEP  = 4;
  localparam logic [15:0] V_LIM = 16'h03e8;
  localparam logic [15:0] V_HI  = 16'h03e9;
  localparam logic [15:0] V_MID = 16'h03b6;
  localparam logic [15:0] V_WRN = 16'h0398;
  localparam logic [15:0] V_LOW = 16'h01f4;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] volt = 16'h0000;
  logic [3:0]  cause = 4'h0;
  logic [7:0]  d, wr_code, wr_data, rd_code, rd_data;
  logic        wr_en, rd_en, rd_valid, clear_faults;
  logic        output_enable, alert_output_n, ov_fault_flag, ov_warn_flag;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;

  always #2.5 core_clk = ~core_clk;

  mov_host HOST (.core_clk, .rd_data, .rd_valid, .wr_en, .wr_code, .wr_data, .rd_en,
    .rd_code, .clear_faults);
  mov_fault_response #(.STEP_CYCLES(STEP)) DUT (.core_clk, .sys_rst, .wr_en, .wr_code,
    .wr_data, .rd_en, .rd_code, .rd_data, .rd_valid, .clear_faults,
    .aux_voltage_monitor_input(volt), .monitor_overvoltage_limit(V_LIM),
    .control_pin_on(~cause[3]), .operation_on(~cause[0]), .bias_ok(~cause[1]),
    .other_fault_shutdown(cause[2]), .output_enable, .alert_output_n, .ov_fault_flag,
    .ov_warn_flag);

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // Whole run is near 460 cycles, so this ceiling only trips on a hang
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic trip(input logic hit);
    cyc(1);
    volt = V_HI;
    #1;
    `CHK("enable on fault", !hit, output_enable)
    cyc(1);
    `CHK("fault flag", hit, ov_fault_flag)
    `CHK("alert", !hit, alert_output_n)
  endtask : trip

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    cyc(3);
    HOST.rd(RESP_OFFSET, d);
    `CHK("reset value", RESP_RESET, d)
    HOST.rd(8'hf7, d);
    `CHK("unmapped read", 8'h00, d)
    for (int i = 0; i < 2; i++) begin
      HOST.wr(RESP_OFFSET, {1'b0, i[0], 6'h3f});
      HOST.rd(RESP_OFFSET, d);
      `CHK("readback", {1'b0, i[0], 6'h3f}, d)
      trip(1'b0);
      volt = V_LOW;
    end
    for (int r = 0; r < 7; r += 3) begin
      HOST.wr(RESP_OFFSET, {2'b10, r[2:0], 3'h0});
      trip(1'b1);
      volt = V_LOW;
      cyc(40);
      `CHK("latched off", 1'b0, output_enable)
      `CHK("flag held", 1'b1, ov_fault_flag)
      HOST.clr();
      cyc(2);
      `CHK("flag cleared", 1'b0, ov_fault_flag)
      `CHK("on after clear", 1'b1, output_enable)
    end
    HOST.wr(RESP_OFFSET, 8'hc0);
    volt = V_WRN;
    cyc(2);
    `CHK("warn flag", 1'b1, ov_warn_flag)
    `CHK("warn keeps on", 1'b1, output_enable)
    trip(1'b1);
    cyc(5);
    `CHK("hiccup held off", 1'b0, output_enable)
    volt = V_LOW;
    cyc(2);
    `CHK("hiccup resume", 1'b1, output_enable)
    `CHK("hiccup flag", 1'b1, ov_fault_flag)
    HOST.clr();
    for (int k = 0; k < 8; k += 7) begin
      HOST.wr(RESP_OFFSET, {5'h17, k[2:0]});
      trip(1'b1);
      volt = V_LOW;
      cyc((k + 1) * STEP - 1);
      `CHK("retry wait", 1'b0, output_enable)
      cyc(1);
      `CHK("retry restart", 1'b1, output_enable)
      `CHK("flag after retry", 1'b1, ov_fault_flag)
      HOST.clr();
    end
    trip(1'b1);
    volt = V_MID;
    cyc(40);
    `CHK("above restart level", 1'b0, output_enable)
    volt = 16'h03b5;
    cyc(1);
    `CHK("below restart level", 1'b1, output_enable)
    HOST.clr();
    HOST.wr(RESP_OFFSET, 8'hbb);
    for (int k = 0; k < 4; k++) begin
      trip(1'b1);
      volt = V_LOW;
      cyc(2);
      cause = 4'h1 << k;
      cyc(4);
      cause = 4'h0;
      cyc(30);
      `CHK("retry stopped", 1'b0, output_enable)
      HOST.clr();
      cyc(4);
      `CHK("on after stop clear", 1'b1, output_enable)
    end
    final_report();
  end
endmodule : mov_fault_response_tb
